// >>> hdl/tsvic_ctrl.sv
// Three source vectored interrupt controller with its control register at 0BH.
// Assumes the core gives phase_two_pulse, data bus writes and return strobes, synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module tsvic_ctrl import tsvic_pkg::*; #(
    parameter int STACK_DEPTH = TSVIC_STACK_DEPTH_SMALL
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic phase_two_pulse_i,
    input wire logic ext_irq_n_i,
    input wire logic timer_overflow_i,
    input wire logic conv_done_i,
    input wire logic [6:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic call_push_i,
    input wire logic isr_exit_instr_i,
    input wire logic subroutine_exit_instr_i,
    input wire logic halted_i,
    output logic [7:0] bus_rdata_o,
    output logic irq_call_o,
    output logic [10:0] irq_vector_o,
    output logic wake_o,
    output logic stack_full_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state and bus decode.

    logic global_irq_enable_reg;
    tsvic_src_type enable_reg;
    tsvic_src_type flag_reg;
    tsvic_src_type flag_next;
    tsvic_src_type hw_set;
    tsvic_src_type serviced;
    tsvic_src_type sampled_reg;
    logic ext_pin_reg;
    logic stack_full;
    logic [2:0] stack_level;
    logic ctrl_wr;
    logic pop;
    logic ack;
    logic [10:0] vector;
    logic [7:0] rdata_reg;
    logic irq_call_reg;
    logic [10:0] irq_vector_reg;
    logic wake_reg;
    logic stack_full_reg;

    // A bit set or clear reaches the core as a full byte write, so one path serves both.
    assign ctrl_wr = bus_wr_i && (bus_addr_i == TSVIC_CTRL_ADDR);
    assign pop = isr_exit_instr_i || subroutine_exit_instr_i;

    function automatic tsvic_src_type pick_highest(input tsvic_src_type req);
        tsvic_src_type g;
        g = '0;
        if (req.ext) begin
            g.ext = 1'b1;
        end else if (req.tmr) begin
            g.tmr = 1'b1;
        end else if (req.conv) begin
            g.conv = 1'b1;
        end
        return g;
    endfunction : pick_highest

    ////////////////////////////////////////////////////////////////////////////
    // Source event detection.

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ext_pin_reg <= 1'b1;
        end else begin
            ext_pin_reg <= ext_irq_n_i;
        end
    end

    // Enables are not consulted here, so a blocked source still latches.
    assign hw_set.ext = ext_pin_reg && !ext_irq_n_i;
    assign hw_set.tmr = timer_overflow_i;
    assign hw_set.conv = conv_done_i;

    ////////////////////////////////////////////////////////////////////////////
    // Sampling and acknowledge.

    // Requests pending since the previous phase two pulse are taken on this one.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            sampled_reg <= '0;
        end else if (phase_two_pulse_i) begin
            sampled_reg <= flag_reg & enable_reg;
        end
    end

    // The enable term uses live bits so a routine that re-enables can nest.
    assign serviced = (phase_two_pulse_i && global_irq_enable_reg && !stack_full) ?
        pick_highest(sampled_reg & flag_reg & enable_reg) : '0;
    assign ack = |serviced;

    always_comb begin
        vector = TSVIC_VEC_CONV;
        if (serviced.ext) begin
            vector = TSVIC_VEC_EXT;
        end else if (serviced.tmr) begin
            vector = TSVIC_VEC_TMR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register.

    always_comb begin
        flag_next = flag_reg;
        if (ctrl_wr) begin
            flag_next.ext = bus_wdata_i[TSVIC_BIT_EXT_FLAG];
            flag_next.tmr = bus_wdata_i[TSVIC_BIT_TMR_FLAG];
            flag_next.conv = bus_wdata_i[TSVIC_BIT_CONV_FLAG];
        end
        flag_next = flag_next & ~serviced;
        flag_next = flag_next | hw_set;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            enable_reg <= '0;
        end else if (ctrl_wr) begin
            enable_reg.ext <= bus_wdata_i[TSVIC_BIT_EXT_EN];
            enable_reg.tmr <= bus_wdata_i[TSVIC_BIT_TMR_EN];
            enable_reg.conv <= bus_wdata_i[TSVIC_BIT_CONV_EN];
        end
    end

    // Acknowledge wins over a same-cycle write so a taken interrupt cannot leave nesting open.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            global_irq_enable_reg <= TSVIC_CTRL_RESET[TSVIC_BIT_GIE];
        end else if (ack) begin
            global_irq_enable_reg <= 1'b0;
        end else if (isr_exit_instr_i) begin
            global_irq_enable_reg <= 1'b1;
        end else if (ctrl_wr) begin
            global_irq_enable_reg <= bus_wdata_i[TSVIC_BIT_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack level and outputs.

    tsvic_stack_level #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .push_i(call_push_i || ack),
        .pop_i(pop),
        .full_o(stack_full),
        .level_o(stack_level)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= {1'b0, flag_next.conv, flag_next.tmr, flag_next.ext, enable_reg.conv,
                          enable_reg.tmr, enable_reg.ext, global_irq_enable_reg} & TSVIC_CTRL_MASK;
        end
    end

    // Only the call strobe and the vector leave this block; status saving is left to software.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            irq_call_reg <= 1'b0;
            irq_vector_reg <= 11'h000;
        end else begin
            irq_call_reg <= ack;
            irq_vector_reg <= ack ? vector : irq_vector_reg;
        end
    end

    // Wake fires on a fresh event only in halt; a flag set before halt does not wake.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wake_reg <= 1'b0;
            stack_full_reg <= 1'b0;
        end else begin
            wake_reg <= halted_i && |(hw_set & ~flag_reg);
            stack_full_reg <= stack_full;
        end
    end

    assign bus_rdata_o = rdata_reg;
    assign irq_call_o = irq_call_reg;
    assign irq_vector_o = irq_vector_reg;
    assign wake_o = wake_reg;
    assign stack_full_o = stack_full_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_ack_clears_gie: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ack |=> !global_irq_enable_reg)
        else $error("global enable not cleared on ack");

    a_blocked_still_latch: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (!global_irq_enable_reg && timer_overflow_i) |=> flag_reg.tmr)
        else $error("blocked request lost");

    a_no_ack_when_full: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        stack_full |-> !ack)
        else $error("ack while stack full");

    a_ext_vector_call: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (serviced.ext && !hw_set.ext) |=> irq_call_o && irq_vector_o == TSVIC_VEC_EXT && !flag_reg.ext)
        else $error("external vector wrong");

    a_timer_vector_call: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        serviced.tmr |=> irq_vector_o == TSVIC_VEC_TMR)
        else $error("timer vector wrong");

    a_conv_vector_call: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        serviced.conv |=> irq_vector_o == TSVIC_VEC_CONV)
        else $error("converter vector wrong");

    a_isr_exit_instr_sets_gie: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (isr_exit_instr_i && !ack) |=> global_irq_enable_reg)
        else $error("return did not enable");

    a_ext_priority_wins: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ack && sampled_reg.ext && flag_reg.ext && enable_reg.ext) |-> serviced.ext)
        else $error("priority order broken");

    a_ack_on_phase: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ack |-> phase_two_pulse_i)
        else $error("ack off phase two");

    a_bit7_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        bus_rdata_o[7] == 1'b0)
        else $error("bit 7 not zero");

    a_set_beats_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (conv_done_i && ctrl_wr) |=> flag_reg.conv)
        else $error("hw set lost to write");

    a_ext_edge_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ext_pin_reg && !ext_irq_n_i) |=> flag_reg.ext)
        else $error("falling edge not latched");

    a_tmr_event_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        timer_overflow_i |=> flag_reg.tmr)
        else $error("timer flag not set");

    a_conv_event_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        conv_done_i |=> flag_reg.conv)
        else $error("converter flag not set");

    a_tmr_ack_clears: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (serviced.tmr && !timer_overflow_i) |=> !flag_reg.tmr)
        else $error("timer flag kept after ack");

    a_conv_ack_clears: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (serviced.conv && !conv_done_i) |=> !flag_reg.conv)
        else $error("converter flag kept after ack");

    a_ack_one_hot: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $onehot0(serviced))
        else $error("more than one source taken");

    a_no_ack_gie_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !global_irq_enable_reg |-> !ack)
        else $error("ack with global enable off");

    a_ack_needs_enable: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (serviced & ~enable_reg) == '0)
        else $error("disabled source taken");

    a_nest_allowed: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (phase_two_pulse_i && global_irq_enable_reg && !stack_full && |(sampled_reg & flag_reg & enable_reg))
        |-> ack)
        else $error("enabled request not taken");

    a_ack_needs_sample: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ack |-> |(sampled_reg & serviced))
        else $error("request taken before it was sampled");

    a_call_after_ack: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ack |=> irq_call_o)
        else $error("no call after ack");

    a_call_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        irq_call_o |=> !irq_call_o)
        else $error("call held too long");

    a_vector_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !ack |=> $stable(irq_vector_o))
        else $error("vector moved without ack");

    a_ack_pushes_level: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ack && !pop) |=> stack_level == $past(stack_level) + 3'h1)
        else $error("ack did not push");

    a_level_bounded: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        stack_level <= 3'(STACK_DEPTH))
        else $error("stack level beyond depth");

    a_flags_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !ctrl_wr |=> (flag_reg & $past(flag_reg & ~serviced)) == $past(flag_reg & ~serviced))
        else $error("flag dropped without service");

    a_write_lands: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ctrl_wr |=> enable_reg.ext == $past(bus_wdata_i[TSVIC_BIT_EXT_EN]))
        else $error("enable write lost");

    a_other_addr_ignored: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (bus_wr_i && bus_addr_i != TSVIC_CTRL_ADDR) |=> $stable(enable_reg))
        else $error("write to other address reached enables");

    a_wake_on_event: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (halted_i && timer_overflow_i && !flag_reg.tmr) |=> wake_o)
        else $error("no wake on new event");

    a_no_wake_running: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !halted_i |=> !wake_o)
        else $error("wake while running");

    a_ret_keeps_gie: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (subroutine_exit_instr_i && !isr_exit_instr_i && !ack && !ctrl_wr)
        |=> global_irq_enable_reg == $past(global_irq_enable_reg))
        else $error("plain return changed global enable");

endmodule : tsvic_ctrl
`default_nettype wire

// >>> hdl/tsvic_pkg.sv
// Package for the three source vectored interrupt controller.
// Assumes a byte-wide data memory bus from the core and a phase two pulse from its sequencer.
package tsvic_pkg;

    localparam logic [6:0] TSVIC_CTRL_ADDR = 7'h0b;
    localparam logic [7:0] TSVIC_CTRL_RESET = 8'h00;
    localparam int TSVIC_BIT_GIE = 0;
    localparam int TSVIC_BIT_EXT_EN = 1;
    localparam int TSVIC_BIT_TMR_EN = 2;
    localparam int TSVIC_BIT_CONV_EN = 3;
    localparam int TSVIC_BIT_EXT_FLAG = 4;
    localparam int TSVIC_BIT_TMR_FLAG = 5;
    localparam int TSVIC_BIT_CONV_FLAG = 6;
    localparam logic [7:0] TSVIC_CTRL_MASK = 8'h7f;
    localparam logic [10:0] TSVIC_VEC_EXT = 11'h004;
    localparam logic [10:0] TSVIC_VEC_TMR = 11'h008;
    localparam logic [10:0] TSVIC_VEC_CONV = 11'h00c;
    localparam int TSVIC_STACK_DEPTH_SMALL = 4;
    localparam int TSVIC_STACK_DEPTH_LARGE = 6;

    // Per-source fields: index 0 external, 1 timer, 2 converter.
    typedef struct packed {
        logic conv;
        logic tmr;
        logic ext;
    } tsvic_src_type;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr;
    } tsvic_bus_type;

endpackage : tsvic_pkg

// >>> hdl/tsvic_stack_level.sv
// Return stack level counter for the interrupt controller.
// Assumes the core pulses push on each call or acknowledge and pop on each return.
`timescale 1ns/1ps
`default_nettype none
module tsvic_stack_level import tsvic_pkg::*; #(
    parameter int DEPTH = TSVIC_STACK_DEPTH_SMALL
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic push_i,
    input wire logic pop_i,
    output logic full_o,
    output logic [2:0] level_o
);

    logic [2:0] stack_level_pointer_reg;

    // A push when full keeps the level: the oldest entry is lost, not counted.
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            stack_level_pointer_reg <= 3'h0;
        end else if (push_i && !pop_i && stack_level_pointer_reg != 3'(DEPTH)) begin
            stack_level_pointer_reg <= stack_level_pointer_reg + 3'h1;
        end else if (pop_i && !push_i && stack_level_pointer_reg != 3'h0) begin
            stack_level_pointer_reg <= stack_level_pointer_reg - 3'h1;
        end
    end

    assign level_o = stack_level_pointer_reg;
    assign full_o = (stack_level_pointer_reg == 3'(DEPTH));

endmodule : tsvic_stack_level
`default_nettype wire

// >>> tb/tsvic_core_model.sv
// Core sequencer model: makes the phase two strobe that paces interrupt sampling.
// Assumes one clock and a synchronous active low reset shared with the controller.
`timescale 1ns/1ps
`default_nettype none
module tsvic_core_model #(
    parameter int PHASE_PERIOD = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    output logic phase_two_pulse_o
);
    logic [3:0] cnt_reg;
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg == 4'(PHASE_PERIOD - 1)) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // One strobe per machine cycle; it stays low in reset so no request is taken early.
    assign phase_two_pulse_o = reset_n_i && (cnt_reg == 4'h0);
endmodule : tsvic_core_model
`default_nettype wire

// >>> tb/tsvic_ctrl_bench.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model paces phase two pulses and the stack depth is four.
`timescale 1ns/1ps
`default_nettype none
module tsvic_ctrl_bench import tsvic_pkg::*;;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ext_n = 1'b1;
    logic tmr = 1'b0;
    logic conv = 1'b0;
    logic wr = 1'b0;
    logic push = 1'b0;
    logic isr_exit_instr = 1'b0;
    logic ret = 1'b0;
    logic halted = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [10:0] vec;
    logic call, wake, full, phase;
    int mismatches = 0;
    int compares = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    tsvic_core_model tsvic_core_model_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .phase_two_pulse_o(phase));
    tsvic_ctrl #(.STACK_DEPTH(TSVIC_STACK_DEPTH_SMALL)) tsvic_ctrl_i (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .phase_two_pulse_i(phase), .ext_irq_n_i(ext_n),
        .timer_overflow_i(tmr), .conv_done_i(conv), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr),
        .call_push_i(push), .isr_exit_instr_i(isr_exit_instr), .subroutine_exit_instr_i(ret), .halted_i(halted),
        .bus_rdata_o(rdata), .irq_call_o(call), .irq_vector_o(vec), .wake_o(wake), .stack_full_o(full));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t: got %h expected %h", $realtime, got, exp);
        end
    endtask : chk
    task automatic wrc(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask : wrc
    // Index 0 to 2 are the sources, 3 plain return, 4 interrupt return, 5 call push.
    task automatic pulse(input int k);
        case (k)
            0: ext_n = 1'b0;
            1: tmr = 1'b1;
            2: conv = 1'b1;
            3: ret = 1'b1;
            4: isr_exit_instr = 1'b1;
            default: push = 1'b1;
        endcase
        tick(1);
        {tmr, conv, ret, isr_exit_instr, push} = 5'h00;
        ext_n = 1'b1;
    endtask : pulse
    task automatic wait_ack(input logic [10:0] exp);
        int n;
        n = 0;
        while (call !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk({10'h000, call}, 11'h001);
        chk(vec, exp);
        tick(1);
    endtask : wait_ack
    task automatic no_ack(input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            tick(1);
            hit = hit | (call !== 1'b0);
        end
        chk({10'h000, hit}, 11'h000);
    endtask : no_ack
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reg();
        chk(rdata, 8'h00);
        wrc(7'h0b, 8'h80);
        tick(1);
        chk(rdata, 8'h00);
        wrc(7'h0c, 8'h0e);
        tick(1);
        chk(rdata, 8'h00);
        wrc(7'h0b, 8'h0e);
        tick(1);
        chk(rdata, 8'h0e);
        $display("register test done");
    endtask : t_reg
    task automatic t_latch();
        pulse(0);
        pulse(1);
        pulse(2);
        no_ack(12);
        chk(rdata, 8'h7e);
        $display("latch test done");
    endtask : t_latch
    task automatic t_prio();
        logic [10:0] vecs [3] = '{11'h004, 11'h008, 11'h00c};
        logic [7:0] after [3] = '{8'h6e, 8'h4e, 8'h0e};
        logic [7:0] cur;
        cur = 8'h7e;
        for (int i = 0; i < 3; i++) begin
            wrc(7'h0b, cur | 8'h01);
            wait_ack(vecs[i]);
            chk(rdata, after[i]);
            pulse(3);
            tick(1);
            chk(rdata, after[i]);
            cur = after[i];
        end
        $display("priority test done");
    endtask : t_prio
    task automatic t_race();
        addr = 7'h0b;
        wdata = 8'h0e;
        wr = 1'b1;
        tmr = 1'b1;
        tick(1);
        wr = 1'b0;
        tmr = 1'b0;
        tick(1);
        chk(rdata, 8'h2e);
        wrc(7'h0b, 8'h00);
        $display("race test done");
    endtask : t_race
    task automatic t_stack();
        repeat (4) pulse(5);
        tick(2);
        chk({10'h000, full}, 11'h001);
        wrc(7'h0b, 8'h05);
        pulse(1);
        no_ack(16);
        pulse(3);
        wait_ack(11'h008);
        pulse(4);
        tick(1);
        chk(rdata, 8'h05);
        repeat (3) pulse(3);
        tick(2);
        chk({10'h000, full}, 11'h000);
        wrc(7'h0b, 8'h00);
        $display("stack test done");
    endtask : t_stack
    task automatic t_wake();
        logic hit;
        halted = 1'b1;
        for (int k = 0; k < 3; k++) begin
            hit = 1'b0;
            pulse(k);
            repeat (4) begin
                hit = hit | (wake === 1'b1);
                tick(1);
            end
            chk({10'h000, hit}, 11'h001);
            wrc(7'h0b, 8'h00);
        end
        halted = 1'b0;
        $display("wake test done");
    endtask : t_wake
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        tick(8);
        reset_n_i = 1'b1;
        tick(1);
        t_reg();
        t_latch();
        t_prio();
        t_race();
        t_stack();
        t_wake();
        give_verdict();
    end
    // The tests need well under a thousand cycles, so this limit only trips on a hang.
    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end
endmodule : tsvic_ctrl_bench
`default_nettype wire
